// file: rtl/reset_sources_pkg.sv
// Constants, field layout and types for the reset-source block
package reset_sources_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int POR_DELAY_CYCLES = 4064;
    localparam int PIN_DRIVE_CYCLES = 4;
    localparam int PIN_SETTLE_CYCLES = 2;
    localparam int SYNC_STAGES = 2;
    localparam int CLKMON_WINDOW_NS = 20000;
    localparam int CLKMON_WINDOW_CYCLES = (CLKMON_WINDOW_NS * 1000) / CLK_PERIOD_PS;
    localparam int WDOG_PRESCALE_BITS = 15;
    localparam int PROTECT_WINDOW_CYCLES = 64;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_OPTION = 8'h01;
    localparam logic [7:0] ADDR_SERVICE = 8'h02;
    localparam logic [7:0] ADDR_TEST = 8'h03;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    localparam int CFG_WDOG_DISABLE_BIT = 2;
    localparam int OPT_RATE_LSB = 0;
    localparam int OPT_FORCE_BIT = 2;
    localparam int OPT_ENABLE_BIT = 3;
    localparam int TEST_INHIBIT_BIT = 7;
    localparam int STAT_CAUSE_LSB = 0;
    localparam int STAT_MODE_BIT = 2;
    localparam int STAT_ARMED_BIT = 3;

    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [7:0] SERVICE_ARM = 8'h55;
    localparam logic [7:0] SERVICE_CLEAR = 8'haa;

    // ------------------------------------------------------------
    // Restart vectors
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_NORM_EXT = 16'hfffe;
    localparam logic [15:0] VEC_NORM_CMON = 16'hfffc;
    localparam logic [15:0] VEC_NORM_WDOG = 16'hfffa;
    localparam logic [15:0] VEC_SPEC_EXT = 16'hbffe;
    localparam logic [15:0] VEC_SPEC_CMON = 16'hbffc;
    localparam logic [15:0] VEC_SPEC_WDOG = 16'hbffa;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CAUSE_EXT,
        CAUSE_CMON,
        CAUSE_WDOG
    } cause_t;

    typedef enum logic [2:0] {
        ST_POR_WAIT,
        ST_PIN_WAIT,
        ST_RUN,
        ST_DRIVE,
        ST_SETTLE
    } seq_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

endpackage

// file: rtl/reset_sources.sv
// Reset sequencer, software watchdog, clock monitor and restart vector select
// ------------------------------------------------------------
// Function
// - After release the restart vector is ready for the first fetch cycles.
// - Normal mode vectors FFFE pin/power-on, FFFC clock monitor, FFFA watchdog.
// - Pin and power-on share a vector; special modes use BFFE, BFFC, BFFA.
// - After power-up wait 4064 cycles, then hold reset while pin low.
// - Internal reset drives the reset pin low for four cycles.
// - Two cycles after release sample pin: low external, high internal.
// - Normal modes: watchdog runs from reset unless disable bit set.
// - Special modes: watchdog resets start inhibited until inhibit bit cleared.
// - Configuration register writable once in normal modes, freely in special.
// - Watchdog counts E divided by 2^15, then by 1, 4, 16, 64.
// - Watchdog rate field resets to 00, the shortest timeout.
// - Protected option bits written once, within 64 cycles, in normal modes.
// - Other bus traffic between arm and clear writes is tolerated.
// - Unserviced enabled watchdog reaching timeout causes system reset.
// - Clock monitor resets when no processor clock edge within window.
// - Monitor enable bit readable, writable anytime, cleared by reset.
// - Force bit enables monitor regardless of enable, until next reset.
// - Below 10 kHz must trip the monitor; 200 kHz or more never.
// ------------------------------------------------------------
`timescale 1ns/1ps

module reset_sources (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire reset_sources_pkg::bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic reset_pin_in,
    output reset_sources_pkg::pin_drive_t reset_pin,
    input wire logic cpu_clk_in,
    input wire logic mode_special_in,
    output logic cpu_reset_n,
    output logic [15:0] restart_vector,
    output reset_sources_pkg::cause_t reset_cause
);
    import reset_sources_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] pin_sync;
    logic [SYNC_STAGES-1:0] clk_sync;
    logic [SYNC_STAGES-1:0] mode_sync;
    logic clk_prev;
    logic pin_level;
    logic clk_edge;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_sync <= '0;
            clk_sync <= '0;
            mode_sync <= '0;
            clk_prev <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[0], reset_pin_in};
            clk_sync <= {clk_sync[0], cpu_clk_in};
            mode_sync <= {mode_sync[0], mode_special_in};
            clk_prev <= clk_sync[1];
        end
    end

    assign pin_level = pin_sync[1];
    assign clk_edge = clk_sync[1] ^ clk_prev;

    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    seq_state_t state;
    logic [11:0] seq_cnt;
    logic hold;
    logic mode_special;
    logic [7:0] config_reg;
    logic config_written;
    logic [1:0] rate;
    logic mon_enable;
    logic mon_force;
    logic options_written;
    logic [6:0] protect_cnt;
    logic test_inhibit;
    logic armed;
    logic [WDOG_PRESCALE_BITS-1:0] prescaler;
    logic [6:0] wd_ticks;
    logic [6:0] wd_last;
    logic wd_tick;
    logic wd_enabled;
    logic wd_fire;
    logic [11:0] mon_cnt;
    logic mon_on;
    logic mon_fire;
    logic wr_config;
    logic wr_option;
    logic wr_service;
    logic wr_test;
    logic protect_open;

    assign hold = !cpu_reset_n;
    assign wr_config = bus.wr && bus.addr == ADDR_CONFIG;
    assign wr_option = bus.wr && bus.addr == ADDR_OPTION;
    assign wr_service = bus.wr && bus.addr == ADDR_SERVICE;
    assign wr_test = bus.wr && bus.addr == ADDR_TEST;
    assign protect_open = mode_special
        || (!options_written && protect_cnt < 7'(PROTECT_WINDOW_CYCLES));

    // ------------------------------------------------------------
    // Mode strap, caught while reset is held
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_special <= 1'b0;
        end else if (hold) begin
            mode_special <= mode_sync[1];
        end
    end

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            config_reg <= CONFIG_RESET;
            config_written <= 1'b0;
        end else if (hold) begin
            config_reg <= CONFIG_RESET;
            config_written <= 1'b0;
        end else if (wr_config && (mode_special || !config_written)) begin
            config_reg <= bus.wdata;
            config_written <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Option register and its write window
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            protect_cnt <= '0;
        end else if (hold) begin
            protect_cnt <= '0;
        end else if (protect_cnt < 7'(PROTECT_WINDOW_CYCLES)) begin
            protect_cnt <= protect_cnt + 7'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rate <= RATE_RESET;
            mon_force <= 1'b0;
            options_written <= 1'b0;
        end else if (hold) begin
            rate <= RATE_RESET;
            mon_force <= 1'b0;
            options_written <= 1'b0;
        end else if (wr_option && protect_open) begin
            rate <= bus.wdata[OPT_RATE_LSB+:2];
            // Force is sticky: a written zero never lowers it
            mon_force <= mon_force | bus.wdata[OPT_FORCE_BIT];
            options_written <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mon_enable <= 1'b0;
        end else if (hold) begin
            mon_enable <= 1'b0;
        end else if (wr_option) begin
            mon_enable <= bus.wdata[OPT_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Test control: watchdog reset inhibit
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            test_inhibit <= 1'b1;
        end else if (hold) begin
            test_inhibit <= 1'b1;
        end else if (wr_test && mode_special) begin
            test_inhibit <= bus.wdata[TEST_INHIBIT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    always_comb begin
        unique case (rate)
            2'h0: wd_last = 7'h00;
            2'h1: wd_last = 7'h03;
            2'h2: wd_last = 7'h0f;
            2'h3: wd_last = 7'h3f;
        endcase
    end

    assign wd_tick = &prescaler;
    assign wd_enabled = !config_reg[CFG_WDOG_DISABLE_BIT]
        && !(mode_special && test_inhibit);
    assign wd_fire = wd_enabled && wd_tick && wd_ticks >= wd_last;

    // Prescaler never clears on service, so timeouts carry one period of slack
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prescaler <= '0;
        end else begin
            prescaler <= prescaler + WDOG_PRESCALE_BITS'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b0;
        end else if (hold) begin
            armed <= 1'b0;
        end else if (wr_service && bus.wdata == SERVICE_ARM) begin
            armed <= 1'b1;
        end else if (wr_service && bus.wdata == SERVICE_CLEAR) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wd_ticks <= '0;
        end else if (hold) begin
            wd_ticks <= '0;
        end else if (wr_service && bus.wdata == SERVICE_CLEAR && armed) begin
            wd_ticks <= '0;
        end else if (wd_tick && wd_enabled) begin
            wd_ticks <= wd_ticks + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Clock monitor
    // ------------------------------------------------------------
    assign mon_on = mon_enable || mon_force;
    assign mon_fire = mon_on && mon_cnt >= 12'(CLKMON_WINDOW_CYCLES - 1);

    // Window sits between the 10 kHz and 200 kHz half periods
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mon_cnt <= '0;
        end else if (hold || clk_edge) begin
            mon_cnt <= '0;
        end else if (mon_cnt < 12'(CLKMON_WINDOW_CYCLES - 1)) begin
            mon_cnt <= mon_cnt + 12'h001;
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    function automatic logic [15:0] vector_of(cause_t c, logic special);
        logic [15:0] v;
        v = VEC_NORM_EXT;
        unique case (c)
            CAUSE_CMON: v = special ? VEC_SPEC_CMON : VEC_NORM_CMON;
            CAUSE_WDOG: v = special ? VEC_SPEC_WDOG : VEC_NORM_WDOG;
            default: v = special ? VEC_SPEC_EXT : VEC_NORM_EXT;
        endcase
        return v;
    endfunction

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_POR_WAIT;
            seq_cnt <= '0;
            cpu_reset_n <= 1'b0;
            reset_pin <= '{out: 1'b0, oe: 1'b0};
            reset_cause <= CAUSE_EXT;
            restart_vector <= VEC_NORM_EXT;
        end else begin
            unique case (state)
                ST_POR_WAIT: begin
                    seq_cnt <= seq_cnt + 12'h001;
                    if (seq_cnt == 12'(POR_DELAY_CYCLES - 1)) begin
                        state <= ST_PIN_WAIT;
                        seq_cnt <= '0;
                    end
                end
                ST_PIN_WAIT: begin
                    if (pin_level) begin
                        state <= ST_RUN;
                        cpu_reset_n <= 1'b1;
                        restart_vector <= vector_of(CAUSE_EXT, mode_sync[1]);
                        reset_cause <= CAUSE_EXT;
                    end
                end
                ST_RUN: begin
                    // Priority: pin, then clock monitor, then watchdog
                    if (!pin_level || mon_fire || wd_fire) begin
                        state <= ST_DRIVE;
                        seq_cnt <= '0;
                        cpu_reset_n <= 1'b0;
                        reset_pin.oe <= 1'b1;
                        if (!pin_level) begin
                            reset_cause <= CAUSE_EXT;
                        end else if (mon_fire) begin
                            reset_cause <= CAUSE_CMON;
                        end else begin
                            reset_cause <= CAUSE_WDOG;
                        end
                    end
                end
                ST_DRIVE: begin
                    seq_cnt <= seq_cnt + 12'h001;
                    if (seq_cnt == 12'(PIN_DRIVE_CYCLES - 1)) begin
                        state <= ST_SETTLE;
                        seq_cnt <= '0;
                        reset_pin.oe <= 1'b0;
                    end
                end
                ST_SETTLE: begin
                    // Extra wait covers the synchroniser so the pin is seen as it
                    // stood two cycles after release
                    seq_cnt <= seq_cnt + 12'h001;
                    if (seq_cnt == 12'(PIN_SETTLE_CYCLES + SYNC_STAGES - 1)) begin
                        seq_cnt <= '0;
                        if (!pin_level) begin
                            state <= ST_PIN_WAIT;
                            reset_cause <= CAUSE_EXT;
                        end else begin
                            state <= ST_RUN;
                            cpu_reset_n <= 1'b1;
                            restart_vector <= vector_of(reset_cause, mode_sync[1]);
                        end
                    end
                end
                default: begin
                    state <= ST_POR_WAIT;
                    seq_cnt <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (bus.rd) begin
            unique case (bus.addr)
                ADDR_CONFIG: rdata <= config_reg;
                ADDR_OPTION: begin
                    rdata <= '0;
                    rdata[OPT_RATE_LSB+:2] <= rate;
                    rdata[OPT_FORCE_BIT] <= mon_force;
                    rdata[OPT_ENABLE_BIT] <= mon_enable;
                end
                ADDR_TEST: begin
                    rdata <= '0;
                    rdata[TEST_INHIBIT_BIT] <= test_inhibit;
                end
                ADDR_STATUS: begin
                    rdata <= '0;
                    rdata[STAT_CAUSE_LSB+:2] <= reset_cause;
                    rdata[STAT_MODE_BIT] <= mode_special;
                    rdata[STAT_ARMED_BIT] <= armed;
                end
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

endmodule

// file: dv/reset_sources_sva.sv
// Port-level checker for the reset-source block
`timescale 1ns/1ps

module reset_sources_sva (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire reset_sources_pkg::bus_req_t bus,
    input wire logic [7:0] rdata,
    input wire logic reset_pin_in,
    input wire reset_sources_pkg::pin_drive_t reset_pin,
    input wire logic cpu_clk_in,
    input wire logic mode_special_in,
    input wire logic cpu_reset_n,
    input wire logic [15:0] restart_vector,
    input wire reset_sources_pkg::cause_t reset_cause
);
    import reset_sources_pkg::*;

    // Raw idle count runs ahead of the synchronised one, hence the small slack
    localparam int IDLE_MIN = 3990;
    int unsigned por_cnt;
    int unsigned idle_cnt;
    logic clk_prev;

    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            por_cnt <= 0;
        end else if (por_cnt < 8191) begin
            por_cnt <= por_cnt + 1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clk_prev <= 1'b0;
            idle_cnt <= 0;
        end else begin
            clk_prev <= cpu_clk_in;
            idle_cnt <= (cpu_clk_in != clk_prev) ? 0 : idle_cnt + 1;
        end
    end

    function automatic logic [15:0] vec_of(input cause_t c, input logic sp);
        case (c)
            CAUSE_WDOG: return sp ? VEC_SPEC_WDOG : VEC_NORM_WDOG;
            CAUSE_CMON: return sp ? VEC_SPEC_CMON : VEC_NORM_CMON;
            default: return sp ? VEC_SPEC_EXT : VEC_NORM_EXT;
        endcase
    endfunction

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    pin_pulse_a: assert property (
        $rose(reset_pin.oe) |-> reset_pin.oe [*4] ##1 !reset_pin.oe)
        else $error("reset pin drive not four cycles");
    pin_low_a: assert property (reset_pin.oe |-> !reset_pin.out)
        else $error("reset pin driven high");
    reset_drive_a: assert property ($fell(cpu_reset_n) |-> $rose(reset_pin.oe))
        else $error("reset entered without pin drive");
    settle_hold_a: assert property ($fell(reset_pin.oe) |-> !cpu_reset_n [*4])
        else $error("reset left before pin sample");
    pin_hold_a: assert property (!reset_pin_in [*5] |=> !cpu_reset_n)
        else $error("running while reset pin low");
    por_delay_a: assert property ($rose(cpu_reset_n) |-> por_cnt >= POR_DELAY_CYCLES)
        else $error("power-on delay too short");
    vector_sel_a: assert property (
        $rose(cpu_reset_n) |-> restart_vector == vec_of(reset_cause, mode_special_in))
        else $error("wrong restart vector");
    vector_stand_a: assert property (
        cpu_reset_n && $past(cpu_reset_n) |-> $stable(restart_vector))
        else $error("restart vector moved while running");
    monitor_idle_a: assert property (
        $fell(cpu_reset_n) && reset_cause == CAUSE_CMON |-> idle_cnt >= IDLE_MIN)
        else $error("clock monitor fired on live clock");
    service_read_a: assert property (
        $past(bus.rd) && $past(bus.addr) == ADDR_SERVICE |-> rdata == 8'h00)
        else $error("service register readable");
endmodule

// file: dv/reset_pin_model.sv
// External reset circuit on the open-drain reset pin
`timescale 1ns/1ps

module reset_pin_model (
    input wire logic ref_clk,
    input wire reset_sources_pkg::pin_drive_t drive,
    input wire logic press,
    output logic pin_level
);
    import reset_sources_pkg::*;

    logic [5:0] stretch = 6'h00;

    // ----------------------------------------
    // Supervisor pulse stretcher
    // ----------------------------------------
    // Long enough to still be low when the device samples the pin
    always_ff @(posedge ref_clk) begin
        if (press) begin
            stretch <= 6'h20;
        end else if (stretch != 6'h00) begin
            stretch <= stretch - 6'h01;
        end
    end

    // Pull-up wins once all parties let go; sharp release, no RC ramp
    assign pin_level = !(drive.oe && !drive.out) && !press && (stretch == 6'h00);
endmodule

// file: dv/tb_reset_sources_watchdog_clock_monitor.sv
// Self-checking testbench for the reset-source block
`timescale 1ns/1ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_reset_sources_watchdog_clock_monitor;
    import reset_sources_pkg::*;

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    bus_req_t bus = '0;
    logic mode_special_in = 1'b0;
    logic cpu_clk_in = 1'b0;
    logic press = 1'b1;
    logic clk_run = 1'b1;
    logic pin_level;
    logic [7:0] rdata;
    pin_drive_t reset_pin;
    logic cpu_reset_n;
    logic [15:0] restart_vector;
    cause_t reset_cause;
    logic [7:0] d;
    logic [31:0] r;
    logic [31:0] seed = 32'h1723;
    int fails = 0;
    int n_tests = 0;
    int n;
    int gap;
    int half = 3;
    int ccnt = 0;

    always #2.5 ref_clk = ~ref_clk;

    // Processor clock activity; half period is half+1 E cycles
    always @(posedge ref_clk) begin
        if (ccnt >= half) begin
            ccnt <= 0;
            if (clk_run) begin
                cpu_clk_in <= ~cpu_clk_in;
            end
        end else begin
            ccnt <= ccnt + 1;
        end
    end

    reset_sources dut (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
        .reset_pin_in(pin_level), .reset_pin(reset_pin), .cpu_clk_in(cpu_clk_in),
        .mode_special_in(mode_special_in), .cpu_reset_n(cpu_reset_n),
        .restart_vector(restart_vector), .reset_cause(reset_cause));

    reset_pin_model pin (.ref_clk(ref_clk), .drive(reset_pin), .press(press),
        .pin_level(pin_level));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [15:0] exp_vec(input cause_t c, input logic sp);
        case (c)
            CAUSE_WDOG: return sp ? VEC_SPEC_WDOG : VEC_NORM_WDOG;
            CAUSE_CMON: return sp ? VEC_SPEC_CMON : VEC_NORM_CMON;
            default: return sp ? VEC_SPEC_EXT : VEC_NORM_EXT;
        endcase
    endfunction

    task automatic summarize();
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Gap cycle after each access keeps one assignment per signal per step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1 d = rdata;
        @(posedge ref_clk);
    endtask

    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (cpu_reset_n !== lvl && n < lim);
        if (cpu_reset_n !== lvl) begin
            `CHK(cpu_reset_n, lvl)
            summarize();
        end
        @(posedge ref_clk);
    endtask

    task automatic sys_rst(input cause_t c, input int lim);
        wait_rst(1'b0, lim);
        gap = n;
        wait_rst(1'b1, 64);
        `CHK(reset_cause, c)
        `CHK(restart_vector, exp_vec(c, mode_special_in))
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4100) @(posedge ref_clk);
        #1 `CHK(cpu_reset_n, 1'b0)
        @(posedge ref_clk);
        press <= 1'b0;
        wait_rst(1'b1, 64);
        `CHK(restart_vector, VEC_NORM_EXT)
        `CHK(reset_cause, CAUSE_EXT)
        rd(ADDR_OPTION);
        `CHK(d, 8'h00)
        rd(ADDR_TEST);
        `CHK(d[TEST_INHIBIT_BIT], 1'b1)
        wr(ADDR_OPTION, 8'h00);
        wr(ADDR_OPTION, 8'h02);
        rd(ADDR_OPTION);
        `CHK(d, 8'h00)
        wr(ADDR_SERVICE, SERVICE_ARM);
        for (int i = 0; i < 4; i++) begin
            r = xs();
            if (r[8]) wr(r[7:0] | 8'h05, r[23:16]);
            rd(r[9] ? ADDR_SERVICE : (r[7:0] | 8'h05));
            `CHK(d, 8'h00)
        end
        rd(ADDR_STATUS);
        `CHK(d[STAT_ARMED_BIT], 1'b1)
        wr(ADDR_SERVICE, SERVICE_CLEAR);
        rd(ADDR_STATUS);
        `CHK(d[STAT_ARMED_BIT], 1'b0)
        sys_rst(CAUSE_WDOG, 40000);
        `CHK(gap <= 32768, 1'b1)
        wr(ADDR_CONFIG, 8'h04);
        wr(ADDR_CONFIG, 8'h00);
        rd(ADDR_CONFIG);
        `CHK(d, 8'h04)
        wr(ADDR_OPTION, 8'h04);
        clk_run <= 1'b0;
        sys_rst(CAUSE_CMON, 4100);
        clk_run <= 1'b1;
        rd(ADDR_OPTION);
        `CHK(d, 8'h00)
        rd(ADDR_CONFIG);
        `CHK(d, CONFIG_RESET)
        wr(ADDR_CONFIG, 8'h04);
        half <= 490;
        repeat (70) @(posedge ref_clk);
        wr(ADDR_OPTION, 8'h0b);
        rd(ADDR_OPTION);
        `CHK(d, 8'h08)
        repeat (1500) @(posedge ref_clk);
        #1 `CHK(cpu_reset_n, 1'b1)
        @(posedge ref_clk);
        clk_run <= 1'b0;
        sys_rst(CAUSE_CMON, 4100);
        clk_run <= 1'b1;
        half <= 3;
        press <= 1'b1;
        @(posedge ref_clk);
        press <= 1'b0;
        sys_rst(CAUSE_EXT, 16);
        resetn <= 1'b0;
        mode_special_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        wait_rst(1'b1, 4200);
        `CHK(restart_vector, VEC_SPEC_EXT)
        rd(ADDR_STATUS);
        `CHK(d[STAT_MODE_BIT], 1'b1)
        wr(ADDR_CONFIG, 8'h04);
        wr(ADDR_CONFIG, 8'h00);
        rd(ADDR_CONFIG);
        `CHK(d, 8'h00)
        wr(ADDR_TEST, 8'h00);
        sys_rst(CAUSE_WDOG, 33000);
        wr(ADDR_OPTION, 8'h08);
        clk_run <= 1'b0;
        sys_rst(CAUSE_CMON, 4100);
        summarize();
    end
endmodule

bind reset_sources reset_sources_sva chk (.ref_clk(ref_clk), .resetn(resetn), .bus(bus),
    .rdata(rdata), .reset_pin_in(reset_pin_in), .reset_pin(reset_pin),
    .cpu_clk_in(cpu_clk_in), .mode_special_in(mode_special_in), .cpu_reset_n(cpu_reset_n),
    .restart_vector(restart_vector), .reset_cause(reset_cause));
